// File: hw/axil_regif.sv
// axi4-lite slave front end that turns bus transfers into register strobes
`timescale 1ns/10ps
`default_nettype none
module axil_regif
    import resizer_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [15:0] awaddr,
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    input  wire logic [15:0] araddr,
    input  wire logic        arvalid,
    output var  logic        arready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    output logic             wr_stb,
    output logic [15:0]      wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_hit,
    output logic             rd_stb,
    output logic [15:0]      rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_hit
);

    logic aw_full_ff;
    logic w_full_ff;
    logic nxt_aw_full;
    logic nxt_w_full;
    logic nxt_bvalid;
    logic nxt_rvalid;

    // write fires once address and data are both held and no answer is pending
    assign wr_stb  = aw_full_ff & w_full_ff & ~bvalid;
    assign rd_stb  = arvalid & arready;
    assign rd_addr = araddr;

    always_comb begin
        nxt_aw_full = (aw_full_ff | (awvalid & awready)) & ~wr_stb;
        nxt_w_full  = (w_full_ff | (wvalid & wready)) & ~wr_stb;
        nxt_bvalid  = wr_stb | (bvalid & ~bready);
        nxt_rvalid  = rd_stb | (rvalid & ~rready);
    end

    // write channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            awready    <= 1'b0;
            wready     <= 1'b0;
            bvalid     <= 1'b0;
            bresp      <= RESP_OKAY;
            wr_addr    <= 16'h0000;
            wr_data    <= 32'h00000000;
            wr_strb    <= 4'h0;
        end else begin
            aw_full_ff <= nxt_aw_full;
            w_full_ff  <= nxt_w_full;
            awready    <= ~nxt_aw_full & ~nxt_bvalid;
            wready     <= ~nxt_w_full & ~nxt_bvalid;
            bvalid     <= nxt_bvalid;
            if (awvalid && awready) begin
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_stb) begin
                bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // read channel; one read in flight, so arready drops while rvalid waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= ~nxt_rvalid;
            rvalid  <= nxt_rvalid;
            if (rd_stb) begin
                rdata <= rd_hit ? rd_data : 32'h00000000;
                rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

endmodule
`default_nettype wire

// File: hw/capture_resizer_control.sv
// register file and control outputs of the capture resizer
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: writing one to soft-reset bit while a resizer is enabled pulses reset.
// R2: writing zero to soft-reset bit does nothing.
// R3: independent bit clear: low rate byte drives both directions.
// R4: independent bit set: low byte horizontal, high byte vertical.
// R5: vsync-update bit clear: new values take effect at once.
// R6: vsync-update bit set: old values kept until next vsync.
// R7: enable bit switches the capture resizer on and off.
// R8: software never enables capture and view resizers together.
// R9: both enables clear stops the resizer block clock.
// R10: start-x register holds an 11-bit horizontal start.
// R11: start-y register holds an 11-bit vertical start.
// R12: software keeps yuv capture sizes even and above minimums.
// R13: rate code n means n/128; zero and above 128 are reserved.
// R14: end-x and end-y registers each hold an 11-bit end position.
// R15: soft-reset bit reads zero; its pulse lasts one clock.
// R16: unused upper bits read zero and ignore writes.
module capture_resizer_control
    import resizer_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [15:0]       awaddr,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    input  wire logic [15:0]       araddr,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [31:0]       rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready,
    input  wire logic              view_en,
    input  wire logic              vsync,
    output var  logic              cap_en_ff,
    output var  logic              clk_run_ff,
    output var  logic              soft_reset_ff,
    output var  logic [RATE_W-1:0] h_rate_ff,
    output var  logic [RATE_W-1:0] v_rate_ff,
    output var  logic              rate_rsvd_ff,
    output window_s                win_act
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // maps a byte address to the one-hot register select
    function automatic reg_sel_e decode(input logic [15:0] addr);
        case (addr[15:2])
            IDX_CTRL:    decode = SEL_CTRL;
            IDX_START_X: decode = SEL_START_X;
            IDX_START_Y: decode = SEL_START_Y;
            IDX_END_X:   decode = SEL_END_X;
            IDX_END_Y:   decode = SEL_END_Y;
            IDX_RATE:    decode = SEL_RATE;
            default:     decode = SEL_NONE;
        endcase
    endfunction

    // byte-lane merge of a 16-bit register, upper bits masked to the field width
    function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] mask);
        logic [15:0] m;
        m = old_v;
        if (s[0]) begin
            m[7:0] = d[7:0];
        end
        if (s[1]) begin
            m[15:8] = d[15:8];
        end
        merge = m & mask;
    endfunction

    // a code is usable when it lies in 1..128
    function automatic logic rate_bad(input logic [RATE_W-1:0] code);
        rate_bad = (code == 8'h00) || (code > RATE_MAX);
    endfunction

    localparam logic [15:0] POS_MASK  = 16'h07FF;
    localparam logic [15:0] CTRL_MASK = 16'h0007;
    localparam logic [15:0] RATE_MASK = 16'hFFFF;

    ////////////////////////////////////////////////////////////////////////////
    // bus front end

    logic        wr_stb;
    logic [15:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        rd_stb;
    logic [15:0] rd_addr;
    logic [31:0] rd_data;
    reg_sel_e    wsel;
    reg_sel_e    rsel;

    axil_regif u_regif (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_stb  (wr_stb),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_hit  (wsel != SEL_NONE),
        .rd_stb  (rd_stb),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_hit  (rsel != SEL_NONE)
    );

    assign wsel = decode(wr_addr);
    assign rsel = decode(rd_addr);

    ////////////////////////////////////////////////////////////////////////////
    // software-visible registers

    logic [15:0] ctrl_ff;
    logic [15:0] start_x_ff;
    logic [15:0] start_y_ff;
    logic [15:0] end_x_ff;
    logic [15:0] end_y_ff;
    logic [15:0] rate_ff;
    logic        srst_req;

    // R16: upper bits masked
    // the soft-reset bit is never stored, so it cannot linger or read back
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff    <= CTRL_RST;
            start_x_ff <= POS_RST;
            start_y_ff <= POS_RST;
            end_x_ff   <= POS_RST;
            end_y_ff   <= POS_RST;
            rate_ff    <= RATE_RST;
        end else if (wr_stb) begin
            case (wsel)
                SEL_CTRL:    ctrl_ff    <= merge(ctrl_ff, wr_data, wr_strb, CTRL_MASK);
                // R10: start x width
                SEL_START_X: start_x_ff <= merge(start_x_ff, wr_data, wr_strb, POS_MASK);
                // R11: start y width
                SEL_START_Y: start_y_ff <= merge(start_y_ff, wr_data, wr_strb, POS_MASK);
                // R14: end positions width
                SEL_END_X:   end_x_ff   <= merge(end_x_ff, wr_data, wr_strb, POS_MASK);
                SEL_END_Y:   end_y_ff   <= merge(end_y_ff, wr_data, wr_strb, POS_MASK);
                SEL_RATE:    rate_ff    <= merge(rate_ff, wr_data, wr_strb, RATE_MASK);
                default:     ctrl_ff    <= ctrl_ff;
            endcase
        end
    end

    // R15: soft-reset bit reads zero
    always_comb begin
        case (rsel)
            SEL_CTRL:    rd_data = {16'h0000, ctrl_ff & CTRL_MASK};
            SEL_START_X: rd_data = {16'h0000, start_x_ff};
            SEL_START_Y: rd_data = {16'h0000, start_y_ff};
            SEL_END_X:   rd_data = {16'h0000, end_x_ff};
            SEL_END_Y:   rd_data = {16'h0000, end_y_ff};
            SEL_RATE:    rd_data = {16'h0000, rate_ff};
            default:     rd_data = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // soft reset

    // R1: one written while a resizer runs
    // R2: a written zero is no request
    assign srst_req = wr_stb && (wsel == SEL_CTRL) && wr_strb[0]
                      && wr_data[CTRL_SRST_BIT] && (ctrl_ff[CTRL_EN_BIT] || view_en);

    // R15: one-clock self-clearing pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_reset_ff <= 1'b0;
        end else begin
            soft_reset_ff <= srst_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings applied to the datapath

    cfg_s cfg_pend;
    cfg_s cfg_act;

    always_comb begin
        cfg_pend.indep       = ctrl_ff[CTRL_INDEP_BIT];
        cfg_pend.win.start_x = start_x_ff[POS_W-1:0];
        cfg_pend.win.start_y = start_y_ff[POS_W-1:0];
        cfg_pend.win.end_x   = end_x_ff[POS_W-1:0];
        cfg_pend.win.end_y   = end_y_ff[POS_W-1:0];
        cfg_pend.rate_hi     = rate_ff[15:8];
        cfg_pend.rate_lo     = rate_ff[7:0];
    end

    // R5: immediate load; R6: hold until vsync
    cfg_shadow u_shadow (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .cfg_pend   (cfg_pend),
        .vsync_mode (ctrl_ff[CTRL_VUPD_BIT]),
        .vsync      (vsync),
        .cfg_act    (cfg_act)
    );

    assign win_act = cfg_act.win;

    // R3: shared rate; R4: independent rates
    // R13: flag codes outside 1..128 so the datapath can refuse them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            h_rate_ff    <= RATE_RST[7:0];
            v_rate_ff    <= RATE_RST[7:0];
            rate_rsvd_ff <= 1'b0;
        end else begin
            h_rate_ff    <= cfg_act.rate_lo;
            v_rate_ff    <= cfg_act.indep ? cfg_act.rate_hi : cfg_act.rate_lo;
            rate_rsvd_ff <= rate_bad(cfg_act.rate_lo)
                            || (cfg_act.indep && rate_bad(cfg_act.rate_hi));
        end
    end

    // R7: enable follows the bit; R9: clock runs only while a resizer is on
    // enable is not deferred to vsync, so switching off takes effect mid-frame
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_en_ff  <= 1'b0;
            clk_run_ff <= 1'b0;
        end else begin
            cap_en_ff  <= ctrl_ff[CTRL_EN_BIT];
            clk_run_ff <= ctrl_ff[CTRL_EN_BIT] | view_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_ctrl_write;
        wr_stb && (wsel == SEL_CTRL) && wr_strb[0];
    endsequence

    sequence s_ctrl_read;
        rd_stb && (rsel == SEL_CTRL);
    endsequence

    a_srst_pulse_once: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        s_ctrl_write and (wr_data[CTRL_SRST_BIT] && (ctrl_ff[CTRL_EN_BIT] || view_en))
        |=> soft_reset_ff ##1 !soft_reset_ff)
        else $error("soft reset did not pulse for one clock");

    a_srst_zero_none: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        !srst_req |=> !soft_reset_ff)
        else $error("soft reset without a written one");

    a_srst_zero_write: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        s_ctrl_write and !wr_data[CTRL_SRST_BIT] |=> !soft_reset_ff)
        else $error("soft reset after a written zero");

    a_rate_shared: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        !cfg_act.indep |=> (v_rate_ff == $past(cfg_act.rate_lo))
                           && (h_rate_ff == $past(cfg_act.rate_lo)))
        else $error("shared rate not applied to both directions");

    a_rate_indep: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        cfg_act.indep |=> v_rate_ff == $past(cfg_act.rate_hi))
        else $error("vertical rate not taken from high byte");

    a_upd_immediate: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        !ctrl_ff[CTRL_VUPD_BIT] |=> cfg_act == $past(cfg_pend))
        else $error("register value not applied at once");

    a_upd_vsync_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        ctrl_ff[CTRL_VUPD_BIT] && !vsync |=> $stable(cfg_act))
        else $error("active settings changed before vsync");

    a_enable_follow: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        s_ctrl_write |=> ##1 cap_en_ff == $past(wr_data[CTRL_EN_BIT], 2))
        else $error("enable output does not follow the written bit");

    a_clock_stop: assert property (@(posedge aclk) disable iff (!aresetn) // R9
        !ctrl_ff[CTRL_EN_BIT] && !view_en |=> !clk_run_ff)
        else $error("resizer clock kept running with both resizers off");

    a_rate_reserved: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        !cfg_act.indep && (cfg_act.rate_lo == 8'h00) |=> rate_rsvd_ff)
        else $error("reserved rate code not flagged");

    a_ctrl_read_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R15
        s_ctrl_read |=> rdata[31:3] == 29'h00000000)
        else $error("soft reset or unused control bits read back");

    a_pos_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        rd_stb && (rsel == SEL_START_X || rsel == SEL_START_Y)
        |=> rdata[31:POS_W] == 21'h000000)
        else $error("unused position bits read back nonzero");

endmodule
`default_nettype wire

// File: hw/cfg_shadow.sv
// active copy of the resizer settings, loaded at once or at the next vsync
`timescale 1ns/10ps
`default_nettype none
module cfg_shadow
    import resizer_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire cfg_s cfg_pend,
    input  wire logic vsync_mode,
    input  wire logic vsync,
    output cfg_s      cfg_act
);

    // in vsync mode the datapath keeps the old values mid-frame so a frame never mixes two settings
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_act <= '{indep: CTRL_RST[CTRL_INDEP_BIT],
                         win: '{start_x: POS_RST[POS_W-1:0], start_y: POS_RST[POS_W-1:0],
                                end_x: POS_RST[POS_W-1:0], end_y: POS_RST[POS_W-1:0]},
                         rate_hi: RATE_RST[15:8], rate_lo: RATE_RST[7:0]};
        end else if (!vsync_mode || vsync) begin
            cfg_act <= cfg_pend;
        end
    end

endmodule
`default_nettype wire

// File: hw/resizer_pkg.sv
// shared constants, field layouts and carrier types of the capture resizer control block
package resizer_pkg;

    // register indices; the byte address is four times the index
    localparam logic [13:0] IDX_CTRL    = 14'h2460;
    localparam logic [13:0] IDX_START_X = 14'h2464;
    localparam logic [13:0] IDX_START_Y = 14'h2466;
    localparam logic [13:0] IDX_END_X   = 14'h2468;
    localparam logic [13:0] IDX_END_Y   = 14'h246A;
    localparam logic [13:0] IDX_RATE    = 14'h246C;

    // control register field positions
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_VUPD_BIT  = 1;
    localparam int CTRL_INDEP_BIT = 2;
    localparam int CTRL_SRST_BIT  = 7;

    // position fields are 11 bits, rate codes 8 bits
    localparam int POS_W  = 11;
    localparam int RATE_W = 8;

    // reset values and the largest usable rate code
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [15:0] POS_RST   = 16'h0000;
    localparam logic [15:0] RATE_RST  = 16'h0808;
    localparam logic [7:0]  RATE_MAX  = 8'h80;

    // axi4-lite responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // one-hot register select
    typedef enum logic [6:0] {
        SEL_NONE    = 7'h01,
        SEL_CTRL    = 7'h02,
        SEL_START_X = 7'h04,
        SEL_START_Y = 7'h08,
        SEL_END_X   = 7'h10,
        SEL_END_Y   = 7'h20,
        SEL_RATE    = 7'h40
    } reg_sel_e;

    // trimming window
    typedef struct packed {
        logic [POS_W-1:0] start_x;
        logic [POS_W-1:0] start_y;
        logic [POS_W-1:0] end_x;
        logic [POS_W-1:0] end_y;
    } window_s;

    // settings that are double buffered against vsync
    typedef struct packed {
        logic              indep;
        window_s           win;
        logic [RATE_W-1:0] rate_hi;
        logic [RATE_W-1:0] rate_lo;
    } cfg_s;

endpackage

// File: sim/capture_feed.sv
// partner model: view resizer enable and vsync source of the capture pipeline
`timescale 1ns/10ps
`default_nettype none
module capture_feed (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       cap_en,
    input  wire logic       view_req,
    input  wire logic       frame_req,
    input  wire logic [3:0] lag,
    output var  logic       view_en_ff,
    output var  logic       vsync_ff
);
    logic [4:0] wait_ff;

    // view held off while capture runs
    always_ff @(posedge aclk) begin
        view_en_ff <= aresetn & view_req & ~cap_en;
    end

    // vsync comes a chosen lag after a frame request, so it can be prompt or slow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_ff  <= 5'h00;
            vsync_ff <= 1'b0;
        end else begin
            vsync_ff <= (wait_ff == 5'h01);
            if (frame_req && wait_ff == 5'h00) begin
                wait_ff <= {1'b0, lag} + 5'h01;
            end else if (wait_ff != 5'h00) begin
                wait_ff <= wait_ff - 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/capture_resizer_control_test.sv
// self-checking bench of the capture resizer control block
`timescale 1ns/10ps
`default_nettype none
module capture_resizer_control_test;
    import resizer_pkg::*;
    logic        aclk = 0, aresetn = 0;
    logic [15:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0]  wstrb = 0, lag = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        view_req = 0, frame_req = 0, view_en, vsync;
    logic        cap_en_ff, clk_run_ff, soft_reset_ff, rate_rsvd_ff;
    logic [7:0]  h_rate_ff, v_rate_ff, lo, hi;
    logic [10:0] sx, sy;
    window_s     win_act, wexp;
    int          errors = 0, num_checks = 0, pulses = 0, p0, i, k, seed;

    always #4 aclk = ~aclk;
    // soft reset pulses counted; a two-cycle pulse counts twice
    always @(posedge aclk) if (soft_reset_ff === 1'b1) pulses++;

    capture_resizer_control dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .view_en, .vsync, .cap_en_ff, .clk_run_ff, .soft_reset_ff,
        .h_rate_ff, .v_rate_ff, .rate_rsvd_ff, .win_act);

    capture_feed feed (.aclk, .aresetn, .cap_en(cap_en_ff), .view_req, .frame_req, .lag,
        .view_en_ff(view_en), .vsync_ff(vsync));

    task automatic wrap_up();
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // a hang ends the run as a failure
    task automatic hang();
        errors++;
        wrap_up();
    endtask

    // write one register word; address and data offered together
    task automatic wr(input logic [13:0] idx, input logic [15:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {16'h0000, d};
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) hang();
        bready <= 1'b0;
        check("bresp", 48'(bresp), 48'(er));
    endtask

    task automatic rd(input logic [13:0] idx, input logic [15:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) hang();
        rready <= 1'b0;
        check("rdata", 48'(rdata), 48'(ed));
        check("rresp", 48'(rresp), 48'(er));
    endtask

    function automatic logic bad(input logic [7:0] c);
        return c == 8'h00 || c > 8'h80;
    endfunction

    initial begin
        seed = $urandom(93);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        // register reset values and unmapped place
        rd(IDX_CTRL, 16'h0000, RESP_OKAY);
        rd(IDX_START_X, 16'h0000, RESP_OKAY);
        rd(IDX_START_Y, 16'h0000, RESP_OKAY);
        rd(IDX_RATE, 16'h0808, RESP_OKAY);
        wr(14'h2462, 16'hFFFF, RESP_SLVERR);
        rd(14'h2462, 16'h0000, RESP_SLVERR);
        // random legal windows, upper bits set and dropped; even sizes, 16 minimum
        for (i = 0; i < 4; i++) begin
            // sizes kept even and above minimum
            sx = 11'($urandom_range(0, 500) * 2);
            sy = 11'($urandom_range(0, 500) * 2);
            wexp = '{sx, sy, sx + 11'(16 + 2 * $urandom_range(0, 200)),
                     sy + 11'(16 + 2 * $urandom_range(0, 200))};
            wr(IDX_START_X, {5'h1F, wexp.start_x}, RESP_OKAY);
            wr(IDX_START_Y, {5'h1F, wexp.start_y}, RESP_OKAY);
            wr(IDX_END_X, {5'h1F, wexp.end_x}, RESP_OKAY);
            wr(IDX_END_Y, {5'h1F, wexp.end_y}, RESP_OKAY);
            repeat (2) @(posedge aclk);
            check("win_act", 48'(win_act), 48'(wexp));
            rd(IDX_START_X, {5'h00, wexp.start_x}, RESP_OKAY);
            rd(IDX_START_Y, {5'h00, wexp.start_y}, RESP_OKAY);
            rd(IDX_END_X, {5'h00, wexp.end_x}, RESP_OKAY);
            rd(IDX_END_Y, {5'h00, wexp.end_y}, RESP_OKAY);
        end
        // rate codes: boundaries, reserved ones and random, shared then independent
        for (i = 0; i < 8; i++) begin
            lo = (i < 4) ? 8'(32'h81FF8000 >> (8 * i)) : 8'($urandom_range(1, 128));
            hi = 8'($urandom);
            for (k = 0; k < 2; k++) begin
                wr(IDX_CTRL, 16'(k * 4), RESP_OKAY);
                wr(IDX_RATE, {hi, lo}, RESP_OKAY);
                repeat (3) @(posedge aclk);
                check("h_rate", 48'(h_rate_ff), 48'(lo));
                check("v_rate", 48'(v_rate_ff), 48'(k ? hi : lo));
                check("rsvd", 48'(rate_rsvd_ff), 48'(bad(lo) | bad(k ? hi : lo)));
            end
        end
        // deferred update: old window stands until the next vsync
        wr(IDX_CTRL, 16'h0002, RESP_OKAY);
        wr(IDX_START_X, {5'h00, ~wexp.start_x}, RESP_OKAY);
        repeat (6) @(posedge aclk);
        check("win_held", 48'(win_act), 48'(wexp));
        wexp.start_x = ~wexp.start_x;
        lag       <= 4'($urandom_range(0, 9));
        frame_req <= 1'b1;
        @(posedge aclk);
        frame_req <= 1'b0;
        for (k = 0; k < 40 && vsync !== 1'b1; k++) @(posedge aclk);
        if (k == 40) hang();
        repeat (3) @(posedge aclk);
        check("win_vsync", 48'(win_act), 48'(wexp));
        // soft reset with both resizers off does nothing; clock stopped
        p0 = pulses;
        wr(IDX_CTRL, 16'h0080, RESP_OKAY);
        repeat (3) @(posedge aclk);
        check("srst_off", 48'(pulses - p0), 48'h0);
        check("clk_run", 48'(clk_run_ff), 48'h0);
        view_req <= 1'b1;
        repeat (3) @(posedge aclk);
        check("clk_view", 48'(clk_run_ff), 48'h1);
        p0 = pulses;
        wr(IDX_CTRL, 16'h0080, RESP_OKAY);
        repeat (3) @(posedge aclk);
        check("srst_view", 48'(pulses - p0), 48'h1);
        view_req <= 1'b0;
        repeat (3) @(posedge aclk);
        wr(IDX_CTRL, 16'h0001, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("cap_en", 48'(cap_en_ff), 48'h1);
        check("clk_cap", 48'(clk_run_ff), 48'h1);
        p0 = pulses;
        wr(IDX_CTRL, 16'h0081, RESP_OKAY);
        repeat (3) @(posedge aclk);
        check("srst_cap", 48'(pulses - p0), 48'h1);
        rd(IDX_CTRL, 16'h0001, RESP_OKAY);
        p0 = pulses;
        wr(IDX_CTRL, 16'h0001, RESP_OKAY);
        repeat (3) @(posedge aclk);
        check("srst_zero", 48'(pulses - p0), 48'h0);
        wr(IDX_CTRL, 16'h0000, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("cap_off", 48'(cap_en_ff), 48'h0);
        check("clk_stop", 48'(clk_run_ff), 48'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
